/* hw/scp_parser.sv */
`timescale 1ns/1ps
`default_nettype none
module scp_parser #(
  parameter int VAL_W = 16
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic rx_valid, // one message byte present
  input wire logic [7:0] rx_data, // message byte
  input wire logic rx_eoi, // byte carries end-or-identify
  output logic rx_ready, // always ready after reset
  output logic cmd_valid, // pulse: a command parsed
  output logic cmd_err, // pulse: a command not recognised
  output scp_pkg::scp_id_t cmd_path, // parent header, or root
  output scp_pkg::scp_id_t cmd_kw, // leaf header or common id
  output logic cmd_query, // command ended in question mark
  output logic cmd_common, // command led by asterisk
  output logic cmd_has_param, // a parameter followed
  output logic [VAL_W-1:0] cmd_value, // rounded parameter value
  output logic cmd_bool, // parameter as boolean
  output logic cmd_reset, // pulse: common reset word
  output logic cmd_selftest, // pulse: common self-test word
  output logic cmd_status, // pulse: common word other than reset or self-test
  input wire logic resp_valid, // executor result present
  input wire logic [31:0] resp_data, // executor result
  input wire logic rd_req, // host reads a response
  output logic out_valid, // pulse: response word out
  output logic [31:0] out_data, // response word
  output logic [7:0] usb_class, // announced interface class
  output logic [7:0] usb_subclass // announced interface subclass
);
  import scp_pkg::*;

  if (VAL_W < 2 || VAL_W > 32) begin : g_bad_width
    $error("VAL_W out of range");
  end

  scp_state_t st_r, st_nxt;
  scp_word_t kbuf_r, kbuf_nxt;
  logic [3:0] klen_r, klen_nxt;
  logic ovf_r, ovf_nxt, com_r, com_nxt, q_r, q_nxt;
  scp_id_t path_r, path_nxt, leaf_r, leaf_nxt;
  logic leaf_ok_r, leaf_ok_nxt, par_r, par_nxt, frac_r, frac_nxt;
  logic rnd_r, rnd_nxt, fdig_r, fdig_nxt;
  logic [VAL_W-1:0] val_r, val_nxt;
  logic cv_r, cv_nxt, ce_r, ce_nxt, cq_r, cq_nxt, cc_r, cc_nxt;
  logic cp_r, cp_nxt, cb_r, cb_nxt, crs_r, crs_nxt;
  logic cst_r, cst_nxt, cstat_r, cstat_nxt;
  scp_id_t cpath_r, cpath_nxt, ckw_r, ckw_nxt;
  logic [VAL_W-1:0] cval_r, cval_nxt;
  logic pend_r, pend_nxt, hold_v_r, hold_v_nxt, ov_r, ov_nxt;
  logic [31:0] hold_r, hold_nxt, od_r, od_nxt;
  logic rdy_r;
  logic [7:0] uc;
  logic is_ws, is_term, is_dig, is_alpha, finish;
  scp_id_t hit;
  logic hit_ok;
  logic [VAL_W-1:0] pval;

  // fold lower case onto upper before matching
  always_comb begin
    is_alpha = (rx_data >= CH_LA) && (rx_data <= CH_LZ);
    uc = is_alpha ? rx_data - CASE_DIFF : rx_data;
    is_ws = (rx_data == CH_TAB) || (rx_data == CH_SP);
    is_term = (rx_data == CH_LF) || rx_eoi;
    is_dig = (rx_data >= CH_0) && (rx_data <= CH_9);
  end

  // header lookup: exact length either the short or the long spelling,
  // so a partial long form such as FREQU is refused
  always_comb begin
    hit = ID_ROOT;
    hit_ok = 1'b0;
    if (!ovf_r && klen_r != 4'h0) begin
      if (com_r) begin
        for (int i = 0; i < NCOM; i++) begin
          if (kbuf_r == COM_WORD[i]) begin
            hit = scp_id_t'(NKW + i);
            hit_ok = 1'b1;
          end
        end
      end else begin
        for (int i = 0; i < NKW; i++) begin
          if (kbuf_r == KW_SHORT[i] || kbuf_r == KW_LONG[i]) begin
            hit = scp_id_t'(i);
            hit_ok = 1'b1;
          end
        end
      end
    end
  end

  // parameter value: ON/OFF words or rounded number
  always_comb begin
    if (kbuf_r == WORD_ON) pval = VAL_W'(1);
    else if (kbuf_r == WORD_OFF) pval = '0;
    else pval = val_r + VAL_W'(rnd_r);
  end

  assign finish = rx_valid && (is_term || rx_data == CH_SEMI);

  // parser state and command issue
  always_comb begin
    st_nxt = st_r; kbuf_nxt = kbuf_r; klen_nxt = klen_r;
    ovf_nxt = ovf_r; com_nxt = com_r; q_nxt = q_r;
    path_nxt = path_r; leaf_nxt = leaf_r; leaf_ok_nxt = leaf_ok_r;
    par_nxt = par_r; frac_nxt = frac_r; rnd_nxt = rnd_r;
    fdig_nxt = fdig_r; val_nxt = val_r;
    cv_nxt = 1'b0; ce_nxt = 1'b0; crs_nxt = 1'b0;
    cst_nxt = 1'b0; cstat_nxt = 1'b0;
    cq_nxt = cq_r; cc_nxt = cc_r; cp_nxt = cp_r; cb_nxt = cb_r;
    cpath_nxt = cpath_r; ckw_nxt = ckw_r; cval_nxt = cval_r;
    if (rx_valid && rx_data != CH_CR) begin // cr before lf is dropped
      if (finish) begin
        if (st_r != ST_KEY || klen_r != 4'h0 || q_r) begin
          // each piece between semicolons issued alone
          if ((st_r == ST_KEY ? hit_ok : leaf_ok_r) && st_r != ST_SKIP) begin
            cv_nxt = 1'b1;
            ckw_nxt = (st_r == ST_KEY) ? hit : leaf_r;
            cpath_nxt = com_r ? ID_ROOT : path_r;
            cq_nxt = q_r;
            cc_nxt = com_r;
            cp_nxt = par_r;
            cval_nxt = pval;
            cb_nxt = (pval != '0);
            if (com_r) begin
              crs_nxt = (ckw_nxt == scp_id_t'(NKW));
              cst_nxt = (ckw_nxt == scp_id_t'(NKW + 1));
              cstat_nxt = (ckw_nxt > scp_id_t'(NKW + 1));
            end
          end else begin
            ce_nxt = 1'b1;
          end
        end
        st_nxt = ST_KEY; kbuf_nxt = '0; klen_nxt = 4'h0;
        ovf_nxt = 1'b0; com_nxt = 1'b0; q_nxt = 1'b0;
        par_nxt = 1'b0; frac_nxt = 1'b0; rnd_nxt = 1'b0;
        fdig_nxt = 1'b0; val_nxt = '0;
        if (is_term) path_nxt = ID_ROOT;
      end else begin
        case (st_r)
          ST_KEY: begin
            if (rx_data == CH_STAR && klen_r == 4'h0) begin
              com_nxt = 1'b1;
            end else if (rx_data == CH_QUERY) begin
              q_nxt = 1'b1;
            end else if (rx_data == CH_COLON && !com_r) begin
              // colon descends a level; leading colon means root
              if (klen_r == 4'h0) path_nxt = ID_ROOT;
              else if (hit_ok) path_nxt = hit;
              else st_nxt = ST_SKIP;
              kbuf_nxt = '0; klen_nxt = 4'h0;
            end else if (is_ws) begin
              if (klen_r != 4'h0) begin
                leaf_nxt = hit; leaf_ok_nxt = hit_ok;
                st_nxt = ST_PARAM;
                kbuf_nxt = '0; klen_nxt = 4'h0;
              end
            end else if (q_r) begin
              st_nxt = ST_SKIP; // no keyword character may follow the mark
            end else if (klen_r == 4'(KW_CHARS)) begin
              ovf_nxt = 1'b1;
            end else begin
              kbuf_nxt = {kbuf_r[KW_BITS-9:0], uc};
              klen_nxt = klen_r + 4'h1;
            end
          end
          ST_PARAM: begin
            if (is_dig) begin
              par_nxt = 1'b1;
              if (!frac_r) val_nxt = VAL_W'(val_r * VAL_W'(10)
                + VAL_W'(rx_data - CH_0));
              else if (!fdig_r) begin
                fdig_nxt = 1'b1;
                rnd_nxt = (rx_data >= CH_5); // round half up
              end
            end else if (rx_data == CH_DOT) begin
              frac_nxt = 1'b1;
            end else if (!is_ws && rx_data != CH_COMMA) begin
              // letters and signs; sign has no effect on magnitude
              par_nxt = 1'b1;
              if (klen_r != 4'(KW_CHARS)) begin
                kbuf_nxt = {kbuf_r[KW_BITS-9:0], uc};
                klen_nxt = klen_r + 4'h1;
              end
            end
          end
          ST_SKIP: ;
          default: st_nxt = ST_KEY;
        endcase
      end
    end
  end

  // response holding: only the newest query result survives
  always_comb begin
    pend_nxt = pend_r;
    hold_v_nxt = hold_v_r;
    hold_nxt = hold_r;
    ov_nxt = 1'b0;
    od_nxt = od_r;
    if (resp_valid && pend_r) begin
      hold_nxt = resp_data;
      hold_v_nxt = 1'b1;
      pend_nxt = 1'b0;
    end else if (rd_req && hold_v_r) begin
      ov_nxt = 1'b1;
      od_nxt = hold_r;
      hold_v_nxt = 1'b0;
    end
    // set wins: a query landing with the old result stays pending
    if (cv_r && cq_r) pend_nxt = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_KEY; kbuf_r <= '0; klen_r <= 4'h0;
      ovf_r <= 1'b0; com_r <= 1'b0; q_r <= 1'b0;
      path_r <= ID_ROOT; leaf_r <= ID_ROOT; leaf_ok_r <= 1'b0;
      par_r <= 1'b0; frac_r <= 1'b0; rnd_r <= 1'b0; fdig_r <= 1'b0;
      val_r <= '0; cv_r <= 1'b0; ce_r <= 1'b0; cq_r <= 1'b0;
      cc_r <= 1'b0; cp_r <= 1'b0; cb_r <= 1'b0; crs_r <= 1'b0;
      cst_r <= 1'b0; cstat_r <= 1'b0; cpath_r <= ID_ROOT;
      ckw_r <= ID_ROOT; cval_r <= '0; pend_r <= 1'b0;
      hold_v_r <= 1'b0; hold_r <= '0; ov_r <= 1'b0; od_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt; kbuf_r <= kbuf_nxt; klen_r <= klen_nxt;
      ovf_r <= ovf_nxt; com_r <= com_nxt; q_r <= q_nxt;
      path_r <= path_nxt; leaf_r <= leaf_nxt; leaf_ok_r <= leaf_ok_nxt;
      par_r <= par_nxt; frac_r <= frac_nxt; rnd_r <= rnd_nxt;
      fdig_r <= fdig_nxt; val_r <= val_nxt; cv_r <= cv_nxt;
      ce_r <= ce_nxt; cq_r <= cq_nxt; cc_r <= cc_nxt; cp_r <= cp_nxt;
      cb_r <= cb_nxt; crs_r <= crs_nxt; cst_r <= cst_nxt;
      cstat_r <= cstat_nxt; cpath_r <= cpath_nxt; ckw_r <= ckw_nxt;
      cval_r <= cval_nxt; pend_r <= pend_nxt; hold_v_r <= hold_v_nxt;
      hold_r <= hold_nxt; ov_r <= ov_nxt; od_r <= od_nxt;
      rdy_r <= 1'b1;
    end
  end

  // class codes are fixed; held in flops so outputs are registered
  logic [7:0] ucls_r, usub_r;
  always_ff @(posedge clk) begin
    ucls_r <= USB_CLASS_TMC;
    usub_r <= USB_SUBCLASS_TMC;
  end

  assign rx_ready = rdy_r; assign cmd_valid = cv_r; assign cmd_err = ce_r;
  assign cmd_path = cpath_r; assign cmd_kw = ckw_r; assign cmd_query = cq_r;
  assign cmd_common = cc_r; assign cmd_has_param = cp_r;
  assign cmd_value = cval_r; assign cmd_bool = cb_r;
  assign cmd_reset = crs_r; assign cmd_selftest = cst_r;
  assign cmd_status = cstat_r; assign out_valid = ov_r;
  assign out_data = od_r; assign usb_class = ucls_r;
  assign usb_subclass = usub_r;

  property p_semi;
    @(posedge clk) disable iff (reset)
      rx_valid && rx_data == CH_SEMI && st_r == ST_KEY && hit_ok && !q_r
      |=> cv_r && ckw_r == $past(hit);
  endproperty
  a_semi: assert property (p_semi) else $error("semi no cmd");
  property p_ws;
    @(posedge clk) disable iff (reset)
      st_r == ST_PARAM && $past(st_r) == ST_KEY |-> $past(is_ws);
  endproperty
  a_ws: assert property (p_ws) else $error("param no space");
  property p_read;
    @(posedge clk) disable iff (reset)
      ov_r |-> $past(rd_req) && od_r == $past(hold_r);
  endproperty
  a_read: assert property (p_read) else $error("unasked out");
  property p_only_query;
    @(posedge clk) disable iff (reset)
      $rose(hold_v_r) |-> $past(pend_r) && (!pend_r || $past(cv_r && cq_r));
  endproperty
  a_only_query: assert property (p_only_query) else $error("stray");
  property p_latest;
    @(posedge clk) disable iff (reset)
      resp_valid && pend_r |=> hold_r == $past(resp_data) && hold_v_r;
  endproperty
  a_latest: assert property (p_latest) else $error("not kept");
  property p_common;
    @(posedge clk) disable iff (reset)
      cv_r && cc_r |-> ckw_r >= scp_id_t'(NKW) && cpath_r == ID_ROOT;
  endproperty
  a_common: assert property (p_common) else $error("misclass");
  property p_root;
    @(posedge clk) disable iff (reset)
      rx_valid && is_term && rx_data != CH_CR |=> path_r == ID_ROOT;
  endproperty
  a_root: assert property (p_root) else $error("not at root");
  property p_bool;
    @(posedge clk) disable iff (reset)
      cv_r |-> cb_r == (cval_r != '0);
  endproperty
  a_bool: assert property (p_bool) else $error("bool wrong");
endmodule // scp_parser
`default_nettype wire

/* hw/scp_pkg.sv */
`default_nettype none
package scp_pkg;
  // character codes seen on the message stream
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_5 = 8'h35;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_DIFF = 8'h20;
  // keyword buffer length, in characters; the longest keyword has 9
  localparam int KW_CHARS = 12;
  localparam int KW_BITS = 8 * KW_CHARS;
  typedef logic [KW_BITS-1:0] scp_word_t;
  typedef logic [4:0] scp_id_t;
  localparam int NKW = 12;
  localparam int NCOM = 9;
  localparam scp_id_t ID_ROOT = 5'h1F;
  // headers: long spelling and the mandatory short spelling
  localparam scp_word_t KW_LONG [NKW] = '{"FREQUENCY", "POWER", "SWEEP",
    "SYSTEM", "STATUS", "CAPTURE", "RF", "START", "STOP", "TYPE",
    "VERSION", "ERROR"};
  localparam scp_word_t KW_SHORT [NKW] = '{"FREQ", "POW", "SWE", "SYST",
    "STAT", "CAPT", "RF", "STAR", "STOP", "TYPE", "VERS", "ERR"};
  // common words, given after the asterisk; ids follow the headers
  localparam scp_word_t COM_WORD [NCOM] = '{"RST", "TST", "CLS", "ESE",
    "ESR", "IDN", "OPC", "SRE", "STB"};
  localparam scp_word_t WORD_ON = "ON";
  localparam scp_word_t WORD_OFF = "OFF";
  // test-and-measurement class codes announced at enumeration
  localparam logic [7:0] USB_CLASS_TMC = 8'hFE;
  localparam logic [7:0] USB_SUBCLASS_TMC = 8'h03;
  typedef enum logic [1:0] {ST_KEY, ST_PARAM, ST_SKIP} scp_state_t;
endpackage
`default_nettype wire

/* tb/scp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host controller model: sends message bytes and pulls responses
module scp_host (
  input wire logic clk, // system clock
  output logic rx_valid, // byte strobe
  output logic [7:0] rx_data, // message byte
  output logic rx_eoi, // end-or-identify with the byte
  output logic rd_req // response read
);
  // idle until the bench asks for traffic
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eoi = 1'b0;
    rd_req = 1'b0;
  end
  // one byte a cycle; a released data line shows the inverse so a stale
  // byte can never pass for a fresh one
  task automatic send(input string s, input bit eoi);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
      rx_eoi <= eoi && (i == s.len() - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_eoi <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // read request held for exactly one edge
  task automatic read();
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
  endtask
endmodule // scp_host
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scp_pkg::*;
  logic clk, reset, rx_valid, rx_eoi, rd_req, resp_valid, rx_ready;
  logic [7:0] rx_data, usb_class, usb_subclass;
  logic [31:0] resp_data, out_data, d;
  logic cmd_valid, cmd_err, cmd_query, cmd_common, cmd_has_param;
  logic cmd_bool, cmd_reset, cmd_selftest, cmd_status, out_valid;
  scp_id_t cmd_path, cmd_kw;
  logic [15:0] cmd_value, n;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h8C3F;
  logic [33:0] cq[$];
  logic [31:0] oq[$];
  scp_parser #(.VAL_W(16)) DUT (.clk(clk), .reset(reset),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi),
    .rx_ready(rx_ready), .cmd_valid(cmd_valid), .cmd_err(cmd_err),
    .cmd_path(cmd_path), .cmd_kw(cmd_kw), .cmd_query(cmd_query),
    .cmd_common(cmd_common), .cmd_has_param(cmd_has_param),
    .cmd_value(cmd_value), .cmd_bool(cmd_bool), .cmd_reset(cmd_reset),
    .cmd_selftest(cmd_selftest), .cmd_status(cmd_status),
    .resp_valid(resp_valid), .resp_data(resp_data), .rd_req(rd_req),
    .out_valid(out_valid), .out_data(out_data), .usb_class(usb_class),
    .usb_subclass(usb_subclass));
  scp_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eoi(rx_eoi), .rd_req(rd_req));
  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // record every command pulse and response word; value only counts
  // when a parameter was given
  always @(posedge clk) begin
    if (cmd_err === 1'b1) cq.push_back({1'b1, 33'h0});
    else if (cmd_valid === 1'b1) cq.push_back({1'b0, cmd_path, cmd_kw,
      cmd_query, cmd_common, cmd_has_param, cmd_reset, cmd_selftest,
      cmd_status, cmd_has_param ? {cmd_bool, cmd_value} : 17'h0});
    if (out_valid === 1'b1) oq.push_back(out_data);
  end
  // hang guard, well above the whole sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      end_sim();
    end
  end
  // expected command record; boolean is value nonzero
  function automatic logic [33:0] mk(scp_id_t p, scp_id_t k,
      logic [2:0] qch, logic [2:0] sg, logic [15:0] v);
    return {1'b0, p, k, qch, sg, qch[0] ? {v != 16'h0, v} : 17'h0};
  endfunction
  // keyword text in random mixed letter case
  function automatic string w2s(scp_word_t w);
    string s;
    logic [7:0] c;
    s = "";
    for (int k = KW_CHARS - 1; k >= 0; k--) begin
      c = w[8*k +: 8];
      if (c >= "A" && c <= "Z" && $random(seed) % 2 != 0) c = c + CASE_DIFF;
      if (c != 8'h00) s = {s, string'(c)};
    end
    return s;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic take(input logic [33:0] e);
    check(cq.size() > 0, 1);
    if (cq.size() > 0) check(cq.pop_front(), e);
  endtask
  // one message, then exactly one command outcome
  task automatic run(input string m, input bit eoi, input logic [33:0] e);
    host.send(m, eoi);
    repeat (3) @(posedge clk);
    take(e);
    check(cq.size(), 0);
  endtask
  // executor result offered for one cycle
  task automatic answer(input logic [31:0] v);
    @(posedge clk);
    resp_valid <= 1'b1;
    resp_data <= v;
    @(posedge clk);
    resp_valid <= 1'b0;
    resp_data <= ~v;
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    resp_valid = 1'b0;
    resp_data = 32'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check(rx_ready, 1);
    check(usb_class, USB_CLASS_TMC);
    check(usb_subclass, USB_SUBCLASS_TMC);
    $display("test reset done");
    for (int i = 0; i < NKW; i++) begin
      run({w2s(KW_LONG[i]), "\n"}, 0, mk(ID_ROOT, scp_id_t'(i), 3'h0, 3'h0, 16'h0));
      run({w2s(KW_SHORT[i]), "\n"}, 0, mk(ID_ROOT, scp_id_t'(i), 3'h0, 3'h0, 16'h0));
    end
    run("FREQU\n", 0, {1'b1, 33'h0});
    run("FRE\n", 0, {1'b1, 33'h0});
    $display("test keywords done");
    run("freq 2.5\n", 0, mk(ID_ROOT, 5'h00, 3'h1, 3'h0, 16'h0003));
    run("POW 2.4\n", 0, mk(ID_ROOT, 5'h01, 3'h1, 3'h0, 16'h0002));
    run("TYPE\t0.4\n", 0, mk(ID_ROOT, 5'h09, 3'h1, 3'h0, 16'h0000));
    run("rf ON\n", 0, mk(ID_ROOT, 5'h06, 3'h1, 3'h0, 16'h0001));
    run("RF OFF\n", 0, mk(ID_ROOT, 5'h06, 3'h1, 3'h0, 16'h0000));
    repeat (4) begin
      n = 16'($random(seed)) & 16'h1FFF;
      run($sformatf("STOP\t%0d\n", n), 0, mk(ID_ROOT, 5'h08, 3'h1, 3'h0, n));
    end
    $display("test parameters done");
    host.send("swe:star 5;STOP 7\n", 0);
    repeat (3) @(posedge clk);
    take(mk(5'h02, 5'h07, 3'h1, 3'h0, 16'h0005));
    take(mk(5'h02, 5'h08, 3'h1, 3'h0, 16'h0007));
    // semicolon straight after a keyword; path kept across it
    host.send("SWE:STAR;stop\n", 0);
    repeat (3) @(posedge clk);
    take(mk(5'h02, 5'h07, 3'h0, 3'h0, 16'h0));
    take(mk(5'h02, 5'h08, 3'h0, 3'h0, 16'h0));
    check(cq.size(), 0);
    run("STOP\n", 0, mk(ID_ROOT, 5'h08, 3'h0, 3'h0, 16'h0));
    run("STAR\r\n", 0, mk(ID_ROOT, 5'h07, 3'h0, 3'h0, 16'h0));
    run("SWE:TYPE 1X", 1, mk(5'h02, 5'h09, 3'h1, 3'h0, 16'h0001));
    run("STOP\n", 0, mk(ID_ROOT, 5'h08, 3'h0, 3'h0, 16'h0));
    $display("test separators done");
    for (int i = 0; i < NCOM; i++) begin
      run({"*", w2s(COM_WORD[i]), "\n"}, 0, mk(ID_ROOT, scp_id_t'(NKW + i), 3'h2, i == 0 ? 3'h4 : (i == 1 ? 3'h2 : 3'h1), 16'h0));
    end
    $display("test common done");
    // result offered with no query pending must never come out
    answer(32'($random(seed)));
    host.read();
    repeat (3) @(posedge clk);
    check(oq.size(), 0);
    run("STOP?X\n", 0, {1'b1, 33'h0});
    run("syst:vers?\n", 0, mk(5'h03, 5'h0A, 3'h4, 3'h0, 16'h0));
    answer(32'($random(seed)));
    run("*IDN?\n", 0, mk(ID_ROOT, 5'h11, 3'h6, 3'h1, 16'h0));
    d = 32'($random(seed));
    answer(d);
    host.read();
    repeat (3) @(posedge clk);
    check(oq.size(), 1);
    if (oq.size() > 0) check(oq.pop_front(), d);
    host.read();
    repeat (3) @(posedge clk);
    check(oq.size(), 0);
    $display("test queries done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
